// ### test_usart_irq_and_ir_pulse_regs.sv
/*
 * Self-checking bench for uirq_regs with a remote station on the pins.
 * Assumes offsets 0x0e pulse length, 0x14 clear, 0x16 set, 0x18 flags.
 */
module test_usart_irq_and_ir_pulse_regs;
    timeunit 1ns;
    timeprecision 1ns;

    logic       clk = 1'b0; // 10 MHz
    logic       rst = 1'b1; // Sync reset
    logic [7:0] addr = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] ev = 8'h00;  // Errors 4:0, break 5, done 6, data write 7
    logic       encoding_select = 1'b0;  // Infrared on
    logic       sde = 1'b0;  // Start detect on
    logic       ab = 1'b0;   // Auto-baud
    logic       unread = 1'b0;
    logic       th_empty = 1'b0;
    logic       rxd, cts, filt, start, irq;
    logic [7:0] rdata, plen;
    int         n_fail = 0;
    int         n_compared = 0;
    int         cyc = 0;

    uirq_regs u_uirq_regs (.clk_i(clk), .rst_i(rst), .addr_i(addr), .wr_i(wr), .rd_i(rd),
        .wdata_i(wdata), .rdata_o(rdata), .encoding_select_i(encoding_select), .start_detect_enable_i(sde),
        .auto_baud_i(ab), .collision_error_i(ev[0]), .sync_field_mismatch_i(ev[1]),
        .rx_overrun_i(ev[2]), .framing_error_i(ev[3]), .parity_error_i(ev[4]),
        .break_char_i(ev[5]), .rx_data_unread_i(unread), .tx_frame_done_i(ev[6]),
        .tx_data_write_i(ev[7]), .tx_holding_empty_i(th_empty), .rxd_i(rxd), .cts_i(cts),
        .rxd_filtered_o(filt), .rx_start_o(start), .ir_min_pulse_length_o(plen), .irq_o(irq));
    uirq_station u_uirq_station (.clk_i(clk), .rxd_o(rxd), .cts_o(cts));

    // ------------------------------------------------------------
    // Clock, hang guard and shared tasks
    // ------------------------------------------------------------
    initial begin
        forever #50 clk = ~clk;
    end

    // Run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            give_verdict();
        end
    end

    task give_verdict;
        if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask

    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data lands one cycle after the strobe
    task rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk($sformatf("reg_%h", a), e, rdata);
    endtask

    task pulse(input int i);
        @(posedge clk);
        ev[i] <= 1'b1;
        @(posedge clk);
        ev[i] <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Both views, zero writes, pulse length, unmapped place
    task t_enables;
        wr_reg(8'h16, 8'hbf);
        rd_chk(8'h14, 8'hbf);
        wr_reg(8'h14, 8'h05);
        rd_chk(8'h16, 8'hba);
        wr_reg(8'h16, 8'h00);
        wr_reg(8'h14, 8'h00);
        rd_chk(8'h14, 8'hba);
        wr_reg(8'h14, 8'hff);
        rd_chk(8'h16, 8'h00);
        wr_reg(8'h0e, 8'ha5);
        rd_chk(8'h0e, 8'ha5);
        chk("plen", 8'ha5, plen);
        wr_reg(8'h20, 8'hff);
        rd_chk(8'h20, 8'h00);
    endtask

    // Each error source, then a zero write that must not clear
    task t_errors;
        for (int i = 0; i < 5; i++) begin
            pulse(i);
            rd_chk(8'h18, 8'h80);
            wr_reg(8'h18, 8'h00);
            rd_chk(8'h18, 8'h80);
            wr_reg(8'h18, 8'h80);
            rd_chk(8'h18, 8'h00);
        end
    endtask

    // Break counts only in auto-baud; clear-to-send edge
    task t_break_cts;
        ab <= 1'b1;
        pulse(5);
        rd_chk(8'h18, 8'h20);
        wr_reg(8'h18, 8'h20);
        ab <= 1'b0;
        pulse(5);
        rd_chk(8'h18, 8'h00);
        u_uirq_station.flip_cts();
        repeat (6) @(posedge clk);
        rd_chk(8'h18, 8'h10);
        wr_reg(8'h18, 8'h10);
        rd_chk(8'h18, 8'h00);
    endtask

    // Transmit complete and the two live flags
    task t_tx_rx;
        pulse(6);
        rd_chk(8'h18, 8'h02);
        pulse(7);
        rd_chk(8'h18, 8'h00);
        pulse(6);
        wr_reg(8'h18, 8'h02);
        @(posedge clk);
        unread <= 1'b1;
        th_empty <= 1'b1;
        rd_chk(8'h18, 8'h05);
        wr_reg(8'h18, 8'h05);
        rd_chk(8'h18, 8'h05);
        @(posedge clk);
        unread <= 1'b0;
        th_empty <= 1'b0;
        rd_chk(8'h18, 8'h00);
    endtask

    // Pulse length L=3: three periods refused, four accepted
    task t_filter;
        logic s;
        wr_reg(8'h0e, 8'h03);
        encoding_select <= 1'b1;
        sde <= 1'b1;
        for (int n = 3; n <= 5; n++) begin
            s = 1'b0;
            if (n == 5) begin
                encoding_select <= 1'b0; // Plain line, no filter
                sde <= 1'b0; // Start must then stay unflagged
            end
            u_uirq_station.low(n == 5 ? 1 : n);
            repeat (8) begin
                @(posedge clk);
                #1 s |= !filt;
            end
            chk("filtered_low", {7'h00, n != 3}, {7'h00, s});
            rd_chk(8'h18, {4'h0, n == 4, 3'h0});
            wr_reg(8'h18, 8'h08);
        end
    endtask

    // Request follows flag and enable, drops with the enable
    task t_irq;
        wr_reg(8'h16, 8'h80);
        pulse(0);
        repeat (3) @(posedge clk);
        #1 chk("irq", 8'h01, {7'h00, irq});
        wr_reg(8'h14, 8'hff);
        repeat (3) @(posedge clk);
        #1 chk("irq", 8'h00, {7'h00, irq});
        wr_reg(8'h18, 8'h80);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd_chk(8'h0e, 8'h00);
        rd_chk(8'h14, 8'h00);
        rd_chk(8'h16, 8'h00);
        rd_chk(8'h18, 8'h00);
        t_enables();
        t_errors();
        t_break_cts();
        t_tx_rx();
        t_filter();
        t_irq();
        give_verdict();
    end
endmodule

// ### uirq_pkg.sv
/*
 * Package for the serial unit's interrupt and infrared pulse register block:
 * register offsets, field positions, reset values and the pulse filter state type.
 * Assumes a simple 8-bit register port with byte offsets as addresses.
 */
package uirq_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_IR_MIN_PULSE_LENGTH = 8'h0e; // Pulse length field
    localparam logic [7:0] OFS_IRQ_ENABLE_CLEAR    = 8'h14; // Enable clear view
    localparam logic [7:0] OFS_IRQ_ENABLE_SET      = 8'h16; // Enable set view
    localparam logic [7:0] OFS_IRQ_FLAGS           = 8'h18; // Flags

    // ------------------------------------------------------------
    // Field positions, shared by enables and flags
    // ------------------------------------------------------------
    localparam int BIT_ERROR            = 7; // Any error
    localparam int BIT_RESERVED         = 6; // Always zero
    localparam int BIT_BREAK_RECEIVED   = 5; // Break in auto-baud
    localparam int BIT_CTS_LEVEL_CHANGE = 4; // Clear-to-send edge
    localparam int BIT_RX_START_SEEN    = 3; // Start condition
    localparam int BIT_RX_COMPLETE      = 2; // Unread data held
    localparam int BIT_TX_COMPLETE      = 1; // Frame shifted out
    localparam int BIT_TX_HOLDING_EMPTY = 0; // Data register empty

    // Bits that software may clear by writing a one
    localparam logic [7:0] W1C_MASK = 8'hba;
    // Bits that may ever read as one
    localparam logic [7:0] IMPL_MASK = 8'hbf;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_PULSE_LENGTH = 8'h00;
    localparam logic [7:0] RST_ENABLES      = 8'h00;
    localparam logic [7:0] RST_FLAGS        = 8'h00;

    // Pulse filter states, Gray along idle, counting, accepted
    typedef enum logic [1:0] {
        UIRQ_PF_IDLE   = 2'b00,
        UIRQ_PF_COUNT  = 2'b01,
        UIRQ_PF_ACCEPT = 2'b11
    } uirq_pf_state_t;

endpackage

// ### uirq_pulse_filter.sv
/*
 * Minimum pulse length filter for the infrared receive path.
 * A low pulse on the synchronised line is passed only once it has lasted
 * (length + 1) clock periods; shorter glitches never reach the output.
 * Assumes line_i is already synchronised to clk_i and idles high.
 */
module uirq_pulse_filter (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       enable_i,
    input  wire logic [7:0] min_len_i,
    input  wire logic       line_i,
    output logic            line_o
);

    uirq_pkg::uirq_pf_state_t state_r; // Filter state
    uirq_pkg::uirq_pf_state_t state_nxt;
    logic [7:0]               cnt_r;   // Cycles of the pulse seen so far minus one
    logic [7:0]               cnt_nxt;
    logic                     out_r;   // Filtered line
    logic                     out_nxt;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        out_nxt   = out_r;
        if (!enable_i) begin
            // Unencoded: line passes straight through, one flop late
            state_nxt = uirq_pkg::UIRQ_PF_IDLE;
            cnt_nxt   = 8'h00;
            out_nxt   = line_i;
        end else begin
            unique case (state_r)
                uirq_pkg::UIRQ_PF_IDLE: begin
                    out_nxt = 1'b1;
                    cnt_nxt = 8'h00;
                    if (!line_i) begin
                        // First cycle of the pulse
                        if (min_len_i == 8'h00) begin
                            state_nxt = uirq_pkg::UIRQ_PF_ACCEPT;
                            out_nxt   = 1'b0;
                        end else begin
                            state_nxt = uirq_pkg::UIRQ_PF_COUNT;
                        end
                    end
                end
                uirq_pkg::UIRQ_PF_COUNT: begin
                    if (line_i) begin
                        // Too short: dropped as noise
                        state_nxt = uirq_pkg::UIRQ_PF_IDLE;
                    end else if (cnt_r + 8'h01 >= min_len_i) begin
                        // Pulse has lasted length + 1 periods
                        state_nxt = uirq_pkg::UIRQ_PF_ACCEPT;
                        out_nxt   = 1'b0;
                    end else begin
                        cnt_nxt = cnt_r + 8'h01;
                    end
                end
                uirq_pkg::UIRQ_PF_ACCEPT: begin
                    if (line_i) begin
                        state_nxt = uirq_pkg::UIRQ_PF_IDLE;
                        out_nxt   = 1'b1;
                    end
                end
                default: begin
                    state_nxt = uirq_pkg::UIRQ_PF_IDLE;
                    out_nxt   = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= uirq_pkg::UIRQ_PF_IDLE;
            cnt_r   <= 8'h00;
            out_r   <= 1'b1;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            out_r   <= out_nxt;
        end
    end

    assign line_o = out_r;

endmodule

// ### uirq_regs.sv
/*
 * Interrupt enable, interrupt flag and infrared pulse length registers of a
 * serial unit. Holds one enable set reached through set and clear views, the
 * event flags, the interrupt request and the infrared receive pulse filter.
 * Assumes the serial engine on the same clock supplies one-cycle event pulses
 * and levels, and that the register port is a simple 8-bit read/write strobe port.
 */

module uirq_regs (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Register port
    input  wire logic [7:0] addr_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    input  wire logic [7:0] wdata_i,
    output logic      [7:0] rdata_o,
    // Control bits from the unit's control register
    input  wire logic       encoding_select_i,
    input  wire logic       start_detect_enable_i,
    input  wire logic       auto_baud_i,
    // Error status events from the receiver
    input  wire logic       collision_error_i,
    input  wire logic       sync_field_mismatch_i,
    input  wire logic       rx_overrun_i,
    input  wire logic       framing_error_i,
    input  wire logic       parity_error_i,
    // Serial engine events and levels
    input  wire logic       break_char_i,
    input  wire logic       rx_data_unread_i,
    input  wire logic       tx_frame_done_i,
    input  wire logic       tx_data_write_i,
    input  wire logic       tx_holding_empty_i,
    // Pins
    input  wire logic       rxd_i,
    input  wire logic       cts_i,
    // Outputs
    output logic            rxd_filtered_o,
    output logic            rx_start_o,
    output logic      [7:0] ir_min_pulse_length_o,
    output logic            irq_o
);

    // Timing at a glance:
    // Writes land at the edge that sees wr_i.
    // Reads answer one cycle later, else zero.
    // Flag events land one edge after input.
    // Request trails flags and enables by one.
    // Pins pass two flops before any logic.
    // Pin change reaches a flag 3 to 4 edges on, rx start 4 + length with encoding on.
    // The filter adds one more flop.

    // Clear and event in one cycle: event wins,
    // so software never loses an event.
    // Limit: a held error input sets the flag
    // again after every clear.
    // Rx complete and data empty are live
    // levels: no storage, never stale.
    // Bit 6 is masked in enables and flags.
    // First access is legal one edge after reset.

    // Enables: one state, two write views.
    // Set view ORs in, clear view masks out.
    // Flags: sticky bits clear on a one write.
    // Length 0 passes a one-cycle pulse.
    // Length is used only with encoding on.
    // No bus wait states are ever inserted.

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [7:0] pulse_len_r;  // Infrared minimum pulse length
    logic [7:0] pulse_len_nxt;
    logic [7:0] enables_r;    // Shared enables behind both views
    logic [7:0] enables_nxt;
    // Sticky order: 4 error, 3 break, 2 cts,
    // 1 rx start, 0 tx complete
    logic [4:0] sticky_r;     // Error, break, cts, start, tx complete
    logic [4:0] sticky_nxt;
    logic       cts_prev_r;   // Last synchronised CTS level
    logic       rx_prev_r;    // Last filtered receive level
    logic [7:0] rdata_r;      // Registered read data
    logic [7:0] rdata_nxt;
    logic       irq_r;        // Registered interrupt request
    logic       irq_nxt;

    // Nets between processes
    logic       cts_sync;     // CTS after two flops
    logic       rxd_sync;     // Receive line after two flops
    logic       rxd_filt;     // After the infrared filter
    logic [7:0] flags;        // Full flag view
    logic       wr_clr;       // Write to enable clear view
    logic       wr_set;       // Write to enable set view
    logic       wr_flags;     // Write to flags
    logic       any_error;    // Any status error this cycle
    logic       cts_edge;     // CTS level change
    logic       rx_start;     // Falling edge on filtered line

    // ------------------------------------------------------------
    // Pin synchronisers and infrared filter
    // ------------------------------------------------------------
    // Pins rest high, so flops reset high;
    // a low reset would fake an edge.
    uirq_sync u_cts_sync (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .d_i       (cts_i),
        .rst_val_i (1'b1),
        .q_o       (cts_sync)
    );

    uirq_sync u_rxd_sync (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .d_i       (rxd_i),
        .rst_val_i (1'b1),
        .q_o       (rxd_sync)
    );

    // Filter is bypassed unless infrared encoding is selected
    // A new length applies at once, also to a pulse being counted
    uirq_pulse_filter u_filter (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .enable_i  (encoding_select_i),
        .min_len_i (pulse_len_r),
        .line_i    (rxd_sync),
        .line_o    (rxd_filt)
    );

    // ------------------------------------------------------------
    // Decode and event detection
    // ------------------------------------------------------------
    // Exact address match; others ignored.
    // Edges compare with last registered level.
    always_comb begin
        wr_clr    = wr_i && (addr_i == uirq_pkg::OFS_IRQ_ENABLE_CLEAR);
        wr_set    = wr_i && (addr_i == uirq_pkg::OFS_IRQ_ENABLE_SET);
        wr_flags  = wr_i && (addr_i == uirq_pkg::OFS_IRQ_FLAGS);
        // Any error source raises the one error flag
        any_error = collision_error_i | sync_field_mismatch_i | rx_overrun_i
                  | framing_error_i | parity_error_i;
        cts_edge  = cts_sync ^ cts_prev_r;
        // Start condition is a falling edge of the cleaned line
        rx_start  = rx_prev_r & ~rxd_filt;
    end

    // ------------------------------------------------------------
    // Flag view: sticky bits plus live levels
    // ------------------------------------------------------------
    // Read and request share this view.
    always_comb begin
        flags = 8'h00; // Reserved bit stays zero
        flags[uirq_pkg::BIT_ERROR]            = sticky_r[4];
        flags[uirq_pkg::BIT_BREAK_RECEIVED]   = sticky_r[3];
        flags[uirq_pkg::BIT_CTS_LEVEL_CHANGE] = sticky_r[2];
        flags[uirq_pkg::BIT_RX_START_SEEN]    = sticky_r[1];
        // Receive complete is a level: it drops when data is read or rx disabled
        flags[uirq_pkg::BIT_RX_COMPLETE]      = rx_data_unread_i;
        flags[uirq_pkg::BIT_TX_COMPLETE]      = sticky_r[0];
        flags[uirq_pkg::BIT_TX_HOLDING_EMPTY] = tx_holding_empty_i;
    end

    // ------------------------------------------------------------
    // Register next values
    // ------------------------------------------------------------
    // Order: writes, then clears, then events;
    // later assignments override earlier ones.
    always_comb begin
        pulse_len_nxt = pulse_len_r;
        enables_nxt   = enables_r;
        sticky_nxt    = sticky_r;
        rdata_nxt     = 8'h00;

        // Pulse length: plain storage
        if (wr_i && (addr_i == uirq_pkg::OFS_IR_MIN_PULSE_LENGTH)) begin
            pulse_len_nxt = wdata_i;
        end
        // One shared enable state; zeros leave bits alone
        if (wr_clr) begin
            enables_nxt = enables_nxt & ~wdata_i;
        end

        // One address per cycle, so no race
        if (wr_set) begin
            enables_nxt = enables_nxt | wdata_i;
        end
        enables_nxt = enables_nxt & uirq_pkg::IMPL_MASK;

        // Clears first, sets after, so an event in the clear cycle survives
        if (wr_flags) begin
            if (wdata_i[uirq_pkg::BIT_ERROR]) begin
                sticky_nxt[4] = 1'b0;
            end
            if (wdata_i[uirq_pkg::BIT_BREAK_RECEIVED]) begin
                sticky_nxt[3] = 1'b0;
            end
            if (wdata_i[uirq_pkg::BIT_CTS_LEVEL_CHANGE]) begin
                sticky_nxt[2] = 1'b0;
            end
            if (wdata_i[uirq_pkg::BIT_RX_START_SEEN]) begin
                sticky_nxt[1] = 1'b0;
            end
            if (wdata_i[uirq_pkg::BIT_TX_COMPLETE]) begin
                sticky_nxt[0] = 1'b0;
            end
        end

        if (tx_data_write_i) begin
            sticky_nxt[0] = 1'b0; // New data cancels completion
        end

        // Error sources merge into one flag
        if (any_error) begin
            sticky_nxt[4] = 1'b1;
        end

        // Break counts only in auto-baud
        if (auto_baud_i && break_char_i) begin
            sticky_nxt[3] = 1'b1;
        end

        // Either direction of the pin counts
        if (cts_edge) begin
            sticky_nxt[2] = 1'b1;
        end

        // Start needs start detection enabled
        if (start_detect_enable_i && rx_start) begin
            sticky_nxt[1] = 1'b1;
        end

        // Frame done with no pending data; a same-cycle data write wins
        if (tx_frame_done_i && !tx_data_write_i) begin
            sticky_nxt[0] = 1'b1;
        end

        // Read data appears one cycle after the read strobe
        // Reads have no side effects here
        if (rd_i) begin
            unique case (addr_i)
                uirq_pkg::OFS_IR_MIN_PULSE_LENGTH: rdata_nxt = pulse_len_r;
                uirq_pkg::OFS_IRQ_ENABLE_CLEAR:    rdata_nxt = enables_r;
                uirq_pkg::OFS_IRQ_ENABLE_SET:      rdata_nxt = enables_r;
                uirq_pkg::OFS_IRQ_FLAGS:           rdata_nxt = flags;
                default:                           rdata_nxt = 8'h00;
            endcase
        end

        // Request is any enabled flag
        // Registered, so it cannot glitch
        irq_nxt = |(flags & enables_r);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Edge history resets to the idle level.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pulse_len_r <= uirq_pkg::RST_PULSE_LENGTH;
            enables_r   <= uirq_pkg::RST_ENABLES;
            sticky_r    <= 5'h00;
            cts_prev_r  <= 1'b1;
            rx_prev_r   <= 1'b1;
            rdata_r     <= 8'h00;
            irq_r       <= 1'b0;
        end else begin
            pulse_len_r <= pulse_len_nxt;
            enables_r   <= enables_nxt;
            sticky_r    <= sticky_nxt;
            cts_prev_r  <= cts_sync;
            rx_prev_r   <= rxd_filt;
            rdata_r     <= rdata_nxt;
            irq_r       <= irq_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Start pulse is a gate on two flops.
    assign rdata_o               = rdata_r;
    assign rxd_filtered_o        = rxd_filt;
    assign rx_start_o            = rx_start;
    assign ir_min_pulse_length_o = pulse_len_r;
    assign irq_o                 = irq_r;

endmodule

// ### uirq_regs_properties.sv
/*
 * Concurrent checks on the interrupt and pulse register block ports.
 * Assumes one clock, synchronous active-high reset, bound onto uirq_regs.
 */
module uirq_checker (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic [7:0] addr_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] wdata_i,
    input wire logic [7:0] rdata_o,
    input wire logic       collision_error_i,
    input wire logic       sync_field_mismatch_i,
    input wire logic       rx_overrun_i,
    input wire logic       framing_error_i,
    input wire logic       parity_error_i,
    input wire logic       rx_data_unread_i,
    input wire logic       tx_holding_empty_i,
    input wire logic       rxd_filtered_o,
    input wire logic       rx_start_o,
    input wire logic [7:0] ir_min_pulse_length_o,
    input wire logic       irq_o
);
    // ------------------------------------------------------------
    // Shadow of the enable state
    // ------------------------------------------------------------
    logic [7:0] en_r;   // Expected enables
    logic [7:0] en_nxt; // Next expected enables

    // Set view ORs, clear view masks; bit 6 can never stick
    always_comb begin
        en_nxt = en_r;
        if (wr_i && addr_i == uirq_pkg::OFS_IRQ_ENABLE_SET) begin
            en_nxt = en_r | (wdata_i & uirq_pkg::IMPL_MASK);
        end else if (wr_i && addr_i == uirq_pkg::OFS_IRQ_ENABLE_CLEAR) begin
            en_nxt = en_r & ~wdata_i;
        end
    end

    // Register only
    always_ff @(posedge clk_i) begin
        en_r <= rst_i ? uirq_pkg::RST_ENABLES : en_nxt;
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Any error event while its enable is on
    sequence s_err_ev;
        en_r[7] && (collision_error_i || sync_field_mismatch_i || rx_overrun_i ||
                    framing_error_i || parity_error_i);
    endsequence

    // Enables quiet for three edges
    sequence s_quiet;
        (en_r == 8'h00) [*3];
    endsequence

    rdata_idle_a: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data not zero without a read");
    unmapped_read_a: assert property (rd_i && !(addr_i inside {8'h0e, 8'h14, 8'h16, 8'h18})
        |=> rdata_o == 8'h00) else $error("unmapped read not zero");
    bit6_zero_a: assert property (rdata_o[6] == 1'b0)
        else $error("reserved bit read as one");
    pulse_len_a: assert property (wr_i && addr_i == uirq_pkg::OFS_IR_MIN_PULSE_LENGTH
        |=> ir_min_pulse_length_o == $past(wdata_i)) else $error("pulse length not written");
    enable_view_a: assert property (rd_i && addr_i inside {8'h14, 8'h16}
        |=> rdata_o == $past(en_r)) else $error("enable view wrong");
    flag_live_a: assert property (rd_i && addr_i == uirq_pkg::OFS_IRQ_FLAGS
        |=> rdata_o[2] == $past(rx_data_unread_i) && rdata_o[0] == $past(tx_holding_empty_i))
        else $error("live flag bits wrong");
    start_edge_a: assert property (rx_start_o == $fell(rxd_filtered_o))
        else $error("start pulse not on filtered falling edge");
    err_irq_a: assert property (s_err_ev |-> ##[1:3] irq_o)
        else $error("error event raised no request");
    irq_off_a: assert property (s_quiet |-> !irq_o)
        else $error("request with no enables");
endmodule

bind uirq_regs uirq_checker u_checker (.*);

// ### uirq_station.sv
/*
 * Remote serial station: drives the receive line and clear-to-send pin.
 * Assumes the bench clock; both lines idle high between activity.
 */
module uirq_station (
    input  wire logic clk_i,
    output logic      rxd_o,
    output logic      cts_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle high, as a pulled-up line would rest
    initial begin
        rxd_o = 1'b1;
        cts_o = 1'b1;
    end

    // Low pulse of n clock periods, launched at an edge
    task low(input int n);
        @(posedge clk_i);
        rxd_o <= 1'b0;
        repeat (n) @(posedge clk_i);
        rxd_o <= 1'b1;
    endtask

    // One level change on clear-to-send
    task flip_cts;
        @(posedge clk_i);
        cts_o <= ~cts_o;
    endtask
endmodule

// ### uirq_sync.sv
/*
 * Two flip-flop synchroniser for one level from a pin.
 * Assumes the input is asynchronous to clk_i; the first stage is read only by the second.
 */
module uirq_sync (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic d_i,
    input  wire logic rst_val_i,
    output logic      q_o
);

    logic meta_r; // First stage
    logic q_r;    // Second stage
    logic meta_nxt;
    logic q_nxt;

    // ------------------------------------------------------------
    // Next values
    // ------------------------------------------------------------
    always_comb begin
        meta_nxt = d_i;
        q_nxt    = meta_r;
    end

    // Synchronous reset takes the idle level given by the parent
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= rst_val_i;
            q_r    <= rst_val_i;
        end else begin
            meta_r <= meta_nxt;
            q_r    <= q_nxt;
        end
    end

    assign q_o = q_r;

endmodule
